// [bit_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [PW-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0] count_ff, nxt_count;
  logic push, pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o = (count_ff != FULL_COUNT);
  assign out_valid_o = (count_ff != '0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count update, wrapping at the last slot
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_SLOT) ? '0 : wr_ptr_ff + PW'(1);
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_SLOT) ? '0 : rd_ptr_ff + PW'(1);
    end
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
  end

  // Storage carries no reset; only written slots are ever read
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end
endmodule

// [display_ctrl_model.sv]
// Behavioural display controller that drives the serial pins of the latch driver
`timescale 1ns/1ns
module display_ctrl_model (
  input wire logic clock_i,
  output logic shift_clk_o,
  output logic serial_data_o,
  output logic latch_strobe_o,
  output logic output_enable_o
);
  // Pins at a known level from time zero
  initial begin
    shift_clk_o = 1'h0;
    serial_data_o = 1'h0;
    latch_strobe_o = 1'h0;
    output_enable_o = 1'h0;
  end

  // One bit in a 200 ns period, two cycles high and two low, clock idle low.
  // With stb set the strobe rises one cycle after the shift edge, the
  // earliest legal point, while the bit may still be queued in the device
  task automatic shift_bit(input logic b, input logic stb = 1'h0);
    @(negedge clock_i);
    serial_data_o = b;
    shift_clk_o = 1'h1;
    @(negedge clock_i);
    latch_strobe_o = stb;
    @(negedge clock_i);
    shift_clk_o = 1'h0;
    serial_data_o = ~b; // Hold time over, line no longer shows the bit
    latch_strobe_o = 1'h0;
    @(negedge clock_i);
  endtask

  // Strobe waits past the last shift edge and ends a cycle before the next one
  task automatic pulse_latch();
    repeat (2) @(negedge clock_i);
    latch_strobe_o = 1'h1;
    @(negedge clock_i);
    latch_strobe_o = 1'h0;
  endtask

  task automatic set_enable(input logic v);
    @(negedge clock_i);
    output_enable_o = v;
  endtask
endmodule

// [latch_bank.sv]
// Transfer latches and output enable gating for each channel
`timescale 1ns/1ns
module latch_bank #(
  parameter int CHANNELS = 32
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic capture_i,
  input wire logic [CHANNELS-1:0] word_i,
  input wire logic output_enable_i,
  output logic [CHANNELS-1:0] latch_o,
  output logic [CHANNELS-1:0] channel_o
);
  logic [CHANNELS-1:0] latch_ff, nxt_latch;
  logic [CHANNELS-1:0] chan_ff, nxt_chan;

  // Latches follow the word while capturing, else hold
  always_comb begin
    nxt_latch = capture_i ? word_i : latch_ff;
  end

  // One gate per channel; enable low forces every channel low
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_gate
      always_comb begin
        nxt_chan[ch] = output_enable_i & nxt_latch[ch];
      end
    end
  endgenerate

  // Latch contents are not reset: undefined until the first transfer
  always_ff @(posedge clock_i) begin
    latch_ff <= nxt_latch;
  end

  // Channel drivers are blanked by reset so the panel starts dark
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      chan_ff <= '0;
    end else begin
      chan_ff <= nxt_chan;
    end
  end

  assign latch_o = latch_ff;
  assign channel_o = chan_ff;
endmodule

// [latch_driver.sv]
// Serial to parallel shift register with latched, gated channel outputs
// Notes on behaviour
// - Thirty-two shift stages, thirty-two transfer latches, and output gating logic.
// - Each rising shift clock edge loads serial input and advances every stage; shift_hold_i stalls the stages and an edge meeting a full queue is lost.
// - Serial data output always shows the last, thirty-second stage for chaining; during reset the code holds it at PIN_RESET instead.
// - Latch strobe and output enable never stall, clear or alter shifting.
// - Latch strobe high makes each latch follow its shift stage; the code delays the transfer until no bits are queued.
// - Latch strobe low makes the latches hold their last captured values; an owed strobe still transfers with strobe low once the queue drains.
// - Output enable low forces all channels low; high passes latch values.
`timescale 1ns/1ns
module latch_driver #(
  parameter int STAGE_COUNT = latch_driver_pkg::STAGES,
  parameter int QUEUE_DEPTH = latch_driver_pkg::FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic latch_strobe_i,
  input wire logic output_enable_i,
  input wire logic shift_hold_i,
  output logic serial_out_o,
  output logic [STAGE_COUNT-1:0] hv_channel_out_o,
  output logic overrun_o
);
  import latch_driver_pkg::*;

  logic sclk_prev_ff, nxt_sclk_prev;
  logic shift_edge;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;
  logic [BIT_WIDTH-1:0] q_out_data;
  logic pop;
  logic [STAGE_COUNT-1:0] shift_ff, nxt_shift;
  logic serial_out_ff, nxt_serial_out;
  logic overrun_ff, nxt_overrun;
  logic strobe_owed_ff, nxt_strobe_owed;
  logic capture;
  logic [STAGE_COUNT-1:0] latch_word;
  // Helper state that tells when the data path holds only known bits
  localparam int FILL_W = $clog2(STAGE_COUNT + 1);
  logic [FILL_W-1:0] fill_ff, nxt_fill;
  logic shift_full;
  logic latch_known_ff, nxt_latch_known;

  // Shift clock is a plain pin sampled at 20 MHz; a rising edge is a
  // low sample followed by a high one. Works because the clock is slow
  always_comb begin
    nxt_sclk_prev = shift_clk_i;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sclk_prev_ff <= PIN_RESET;
    end else begin
      sclk_prev_ff <= nxt_sclk_prev;
    end
  end

  assign shift_edge = shift_clk_i && !sclk_prev_ff;

  // Each edge queues the sampled serial bit; the queue absorbs
  // a hold from the drain side of up to QUEUE_DEPTH edges without dropping bits
  bit_fifo #(
    .WIDTH(BIT_WIDTH),
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(shift_edge),
    .in_ready_o(q_in_ready),
    .in_data_i(serial_in_i),
    .out_valid_o(q_out_valid),
    .out_ready_i(q_out_ready),
    .out_data_o(q_out_data)
  );

  // Drain stalls only on the hold input, never on strobe or enable
  assign q_out_ready = !shift_hold_i;
  assign pop = q_out_valid && q_out_ready;

  // Shift register: first stage takes the queued bit, the rest move on
  always_comb begin
    nxt_shift = shift_ff;
    if (pop) begin
      nxt_shift = {shift_ff[STAGE_COUNT-2:0], q_out_data};
    end
    nxt_serial_out = nxt_shift[STAGE_COUNT-1];
  end

  // No reset on the data path; contents are garbage until filled.
  // Saves a reset net across every stage at the cost of a fill time
  always_ff @(posedge clock_i) begin
    shift_ff <= nxt_shift;
  end

  // Counts bits moved in since reset, stopping at the stage count. Until
  // it stops, some stages still hold power-up garbage, so the whole-word
  // checks below wait for it rather than compare unknown values
  always_comb begin
    nxt_fill = fill_ff;
    if (pop && !shift_full) begin
      nxt_fill = fill_ff + FILL_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fill_ff <= '0;
    end else begin
      fill_ff <= nxt_fill;
    end
  end

  assign shift_full = (fill_ff == FILL_W'(STAGE_COUNT));

  // Chain output mirrors the last stage in the same cycle it changes
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      serial_out_ff <= PIN_RESET;
    end else begin
      serial_out_ff <= nxt_serial_out;
    end
  end

  // Sticky overrun: an edge arrived while the queue was full and
  // that bit is lost; only reset clears it
  always_comb begin
    nxt_overrun = overrun_ff;
    if (shift_edge && !q_in_ready) begin
      nxt_overrun = 1'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      overrun_ff <= FLAG_RESET;
    end else begin
      overrun_ff <= nxt_overrun;
    end
  end

  // Transfer waits until queued bits have reached the register, so a
  // strobe placed after the last edge latches that edge's bit. A strobe
  // that ends while bits are still queued is owed and applied later.
  always_comb begin
    nxt_strobe_owed = strobe_owed_ff;
    if (latch_strobe_i && q_out_valid) begin
      nxt_strobe_owed = 1'h1;
    end else if (!q_out_valid) begin
      nxt_strobe_owed = 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strobe_owed_ff <= FLAG_RESET;
    end else begin
      strobe_owed_ff <= nxt_strobe_owed;
    end
  end

  assign capture = (latch_strobe_i || strobe_owed_ff) && !q_out_valid;

  // Marks latches that took a fully loaded register; before that the
  // channels may show garbage if the enable is raised early
  always_comb begin
    nxt_latch_known = latch_known_ff;
    if (capture && shift_full) begin
      nxt_latch_known = 1'h1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      latch_known_ff <= FLAG_RESET;
    end else begin
      latch_known_ff <= nxt_latch_known;
    end
  end

  // Latches and the per-channel enable gates
  latch_bank #(
    .CHANNELS(STAGE_COUNT)
  ) u_latches (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .capture_i(capture),
    .word_i(shift_ff),
    .output_enable_i(output_enable_i),
    .latch_o(latch_word),
    .channel_o(hv_channel_out_o)
  );

  assign serial_out_o = serial_out_ff;
  assign overrun_o = overrun_ff;

  // Checks on the logic above. Those that compare whole words wait until
  // the register, or the latches, have been loaded from known bits, since
  // nothing on the data path is reset

  sequence s_edge_accepted;
    shift_edge && q_in_ready;
  endsequence

  sequence s_edge_refused;
    shift_edge && !q_in_ready;
  endsequence

  sequence s_bit_popped;
    pop;
  endsequence

  sequence s_strobe_while_queued;
    latch_strobe_i && q_out_valid && !shift_hold_i;
  endsequence

  sequence s_queue_drained;
    !q_out_valid && shift_full;
  endsequence

  a_edge_queues_bit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_edge_accepted |=> q_out_valid)
    else $error("accepted shift edge did not queue a bit");

  a_overrun_sticks: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_edge_refused |=> overrun_o ##1 overrun_o)
    else $error("overrun flag not set and held after a refused edge");

  a_first_stage_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_bit_popped |=> shift_ff[0] == $past(q_out_data))
    else $error("first stage did not take the queued bit");

  a_stages_advance: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_bit_popped ##0 shift_full |=> shift_ff[STAGE_COUNT-1:1] == $past(shift_ff[STAGE_COUNT-2:0]))
    else $error("stages did not move on by one");

  a_shift_idle_stable: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!pop && shift_full) |=> $stable(shift_ff))
    else $error("shift register changed without a queued bit");

  a_strobe_no_stall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (q_out_valid && !shift_hold_i && (latch_strobe_i || !output_enable_i)) |-> pop)
    else $error("strobe or enable stalled shifting");

  a_chain_tail: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    shift_full |-> serial_out_o == shift_ff[STAGE_COUNT-1])
    else $error("serial output differs from last stage");

  a_latch_follow: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (latch_strobe_i && !q_out_valid && shift_full) |=> latch_word == $past(shift_ff))
    else $error("latches did not follow the shift register");

  a_latch_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!latch_strobe_i && !strobe_owed_ff && latch_known_ff) |=> $stable(latch_word))
    else $error("latches changed with strobe low");

  a_owed_strobe_done: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (latch_strobe_i && q_out_valid && !shift_hold_i) ##1 !shift_hold_i[*4]
      |-> ##[0:1] (!strobe_owed_ff && !q_out_valid))
    else $error("owed transfer not applied after the queue drained");

  a_enable_low_blank: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !output_enable_i |=> hv_channel_out_o == '0)
    else $error("channels not forced low with enable low");

  a_enable_high_pass: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (output_enable_i && latch_known_ff) |=> hv_channel_out_o == latch_word)
    else $error("channels do not show latch values with enable high");

  a_channels_blank_reset: assert property (@(posedge clock_i)
    !rst_n_i |=> hv_channel_out_o == '0 && serial_out_o == PIN_RESET && !overrun_o)
    else $error("outputs not cleared by reset");

  a_owed_strobe_lands: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_strobe_while_queued ##1 s_queue_drained |=> latch_word == $past(shift_ff))
    else $error("owed transfer did not latch the drained register");

  a_owed_applied_once: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (strobe_owed_ff && !q_out_valid) |=> !strobe_owed_ff)
    else $error("owed transfer not cleared once applied");

  a_edge_single: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    shift_edge |=> !shift_edge)
    else $error("one shift clock rise seen as two edges");

  a_chain_next_stage: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    s_bit_popped ##0 shift_full |=> serial_out_o == $past(shift_ff[STAGE_COUNT-2]))
    else $error("serial output did not take the next stage");

  a_channels_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (output_enable_i && !latch_strobe_i && !strobe_owed_ff && latch_known_ff) ##1
      (output_enable_i && !latch_strobe_i && !strobe_owed_ff) |=> $stable(hv_channel_out_o))
    else $error("channels changed with strobe low");

  a_hold_freezes: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (shift_hold_i && shift_full) |=> $stable(shift_ff))
    else $error("shift register moved while drain held");
endmodule

// [latch_driver_pkg.sv]
// Shared constants for the serial to parallel latch driver
package latch_driver_pkg;
  // Structure
  localparam int STAGES = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int BIT_WIDTH = 1;

  // System clock
  localparam int CLK_PERIOD_NS = 50;

  // Timing the controller keeps on the pins
  localparam int SCLK_MAX_KHZ = 8000;
  localparam int SCLK_MIN_PERIOD_NS = 1000000 / SCLK_MAX_KHZ;
  localparam int SCLK_MIN_WIDTH_NS = 62;
  localparam int LE_DELAY_NS = 50;
  localparam int LE_WIDTH_NS = 50;
  localparam int LE_SETUP_NS = 50;

  // Least times rounded up to whole system clock cycles
  localparam int SCLK_MIN_WIDTH_CYC = (SCLK_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_MIN_PERIOD_CYC = (SCLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LE_WIDTH_CYC = (LE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset values of control state and outputs
  localparam logic FLAG_RESET = 1'h0;
  localparam logic PIN_RESET = 1'h0;
endpackage

// [tb_top.sv]
// Self-checking testbench for the serial to parallel latch driver
`timescale 1ns/1ns
module tb_top;
  import latch_driver_pkg::*;
  localparam int CYCLE_LIMIT = 5000;
  logic clock_i;
  logic rst_n_i;
  logic shift_hold_i;
  logic shift_clk;
  logic serial_data;
  logic strobe;
  logic enable;
  logic serial_out;
  logic [STAGES-1:0] hv;
  logic overrun;
  logic [STAGES-1:0] sr;
  int err_count;
  int tests_run;
  int cycles;

  latch_driver i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk), .serial_in_i(serial_data),
    .latch_strobe_i(strobe), .output_enable_i(enable), .shift_hold_i(shift_hold_i), .serial_out_o(serial_out),
    .hv_channel_out_o(hv), .overrun_o(overrun));
  display_ctrl_model i_ctrl (.clock_i(clock_i), .shift_clk_o(shift_clk), .serial_data_o(serial_data),
    .latch_strobe_o(strobe), .output_enable_o(enable));

  // System clock, 50 ns period
  initial begin
    clock_i = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
  end

  task automatic check_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic check_word(input logic [STAGES-1:0] got, input logic [STAGES-1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard: the full sequence needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      err_count++;
      $display("ERROR t=%0t run did not finish", $time);
      print_verdict();
    end
  end

  // Six cycles of reset; outputs are judged while it is held, since the
  // chain output follows an unreset stage from the first edge after release
  task automatic do_reset();
    rst_n_i = 1'h0;
    repeat (6) @(negedge clock_i);
    check_bit(serial_out, PIN_RESET, "serial out in reset");
    check_word(hv, '0, "channels in reset");
    check_bit(overrun, FLAG_RESET, "overrun in reset");
    rst_n_i = 1'h1;
    @(negedge clock_i);
  endtask

  // Shift one bit and keep the reference copy of the register in step
  task automatic tb_shift(input logic b, input logic stb = 1'h0);
    i_ctrl.shift_bit(b, stb);
    sr = {sr[STAGES-2:0], b};
  endtask

  // First bit sent lands in the last stage
  task automatic send_word(input logic [STAGES-1:0] w);
    for (int i = STAGES - 1; i >= 0; i--) begin
      tb_shift(w[i]);
    end
  endtask

  task automatic t_reset();
    do_reset();
    check_word(hv, '0, "channels after reset");
    check_bit(overrun, FLAG_RESET, "overrun after reset");
  endtask

  task automatic t_load(input logic [STAGES-1:0] w);
    send_word(w);
    i_ctrl.pulse_latch();
    i_ctrl.set_enable(1'h1);
    @(negedge clock_i);
    check_word(hv, w, "channels after first load");
  endtask

  // Strobe low: outputs hold while the chain output walks through the register
  task automatic t_hold_chain(input logic [STAGES-1:0] old_w, input logic [STAGES-1:0] w);
    for (int i = STAGES - 1; i >= 0; i--) begin
      tb_shift(w[i]);
      check_bit(serial_out, sr[STAGES-1], "chain output");
      check_word(hv, old_w, "channels held");
    end
    i_ctrl.pulse_latch();
    check_word(hv, w, "channels after second load");
  endtask

  // Strobe raised while the last bit still waits in the queue: it is owed
  // and must latch the word that includes that bit
  task automatic t_late_strobe(input logic [STAGES-1:0] w);
    for (int i = STAGES - 1; i > 0; i--) begin
      tb_shift(w[i]);
    end
    tb_shift(w[0], 1'h1);
    check_word(hv, w, "strobe while last bit queued");
    check_bit(serial_out, sr[STAGES-1], "chain output after late strobe");
  endtask

  task automatic t_enable(input logic [STAGES-1:0] w);
    i_ctrl.set_enable(1'h0);
    @(negedge clock_i);
    check_word(hv, '0, "channels disabled");
    send_word(w);
    i_ctrl.pulse_latch();
    check_word(hv, '0, "still disabled after load");
    i_ctrl.set_enable(1'h1);
    @(negedge clock_i);
    check_word(hv, w, "channels enabled");
  endtask

  // Stalled queue takes four bits, the fifth edge is lost
  task automatic t_overrun();
    @(negedge clock_i);
    shift_hold_i = 1'h1;
    repeat (4) i_ctrl.shift_bit(1'h1);
    check_bit(overrun, 1'h0, "no overrun at four");
    i_ctrl.shift_bit(1'h0);
    check_bit(overrun, 1'h1, "overrun at five");
    shift_hold_i = 1'h0;
    i_ctrl.set_enable(1'h0);
    do_reset();
    check_bit(overrun, 1'h0, "overrun cleared by reset");
  endtask

  // Main sequence
  initial begin
    shift_hold_i = 1'h0;
    sr = '0;
    err_count = 0;
    tests_run = 0;
    cycles = 0;
    t_reset();
    t_load(32'h8001a5c3);
    t_hold_chain(32'h8001a5c3, 32'h5a3c0ff1);
    t_late_strobe(32'h3c5a96e1);
    t_enable(32'hc0de1234);
    t_overrun();
    print_verdict();
  end
endmodule
